// file: cascade_cfg.svh
`ifndef CASCADE_CFG_SVH
`define CASCADE_CFG_SVH

// ----------------------------------------------------------------
// Slice and register map
// ----------------------------------------------------------------
`define SLICE_W 18
`define SLICE_PAD 14
`define MAX_SLICES 8
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_FLAGS 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10
`define DATA_BLOCK_W 3'h1
`define DATA_BLOCK_R 3'h2

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_W 3
`define CTRL_RESET 3'h0
`define CMD_PUSH_BIT 0
`define CMD_POP_BIT 1
`define CMD_REPLAY_BIT 2
`define FLAGS_HALF_VALID_BIT 5
`define FLAGS_BUSY_BIT 6
`define IRQ_W 6
`define MASK_RESET 6'h00
`define EV_PUSH_DONE 0
`define EV_POP_DONE 1
`define EV_PUSH_REFUSED 2
`define EV_POP_REFUSED 3
`define EV_REPLAY_REFUSED 4
`define EV_EMPTY_REACHED 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define REPLAY_PULSE_NS 12
`define REPLAY_RECOVER_NS 12
`define REPLAY_PULSE_CYC ((`REPLAY_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REPLAY_RECOVER_CYC ((`REPLAY_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W 4

`endif

// file: cascade_pkg.sv
`include "cascade_cfg.svh"

package cascade_pkg;

    // Active-low flag set of one device, or the composite of all devices
    typedef struct packed {
        logic near_full_n;
        logic near_empty_n;
        logic half_n;
        logic full_n;
        logic empty_n;
    } dev_flags_s;

    // Software control word
    typedef struct packed {
        logic offset_load;
        logic out_enable;
        logic depth_mode;
    } ctrl_s;

    // Transfer sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ = 3'b010,
        ST_CAPTURE = 3'b011,
        ST_REPLAY = 3'b100,
        ST_RECOVER = 3'b101
    } seq_state_e;

endpackage

// file: flag_combine.sv
`timescale 1ns/10ps
`default_nettype none

module flag_combine #(
    parameter int NUM_DEV = 3
) (
    input wire logic depth_mode_in,                                  // 1: chain, 0: side by side
    input wire cascade_pkg::dev_flags_s [NUM_DEV-1:0] dev_flags_in,  // Flags of every device
    output cascade_pkg::dev_flags_s comp_flags_out                   // Composite flags
);

    // ----------------------------------------------------------------
    // Merge
    // ----------------------------------------------------------------
    // Chain: OR of active-low flags; side by side: AND of them
    function automatic logic merge(input logic [NUM_DEV-1:0] v, input logic depth);
        return depth ? |v : &v;
    endfunction

    logic [NUM_DEV-1:0] empty_v;
    logic [NUM_DEV-1:0] full_v;
    logic [NUM_DEV-1:0] half_v;
    logic [NUM_DEV-1:0] near_empty_v;
    logic [NUM_DEV-1:0] near_full_v;

    // Gather one vector per flag; no device count limit here
    for (genvar i = 0; i < NUM_DEV; i++) begin : g_dev
        assign empty_v[i] = dev_flags_in[i].empty_n;
        assign full_v[i] = dev_flags_in[i].full_n;
        assign half_v[i] = dev_flags_in[i].half_n;
        assign near_empty_v[i] = dev_flags_in[i].near_empty_n;
        assign near_full_v[i] = dev_flags_in[i].near_full_n;
    end

    // R03 side-by-side AND
    // R10 chain OR
    assign comp_flags_out.empty_n = merge(empty_v, depth_mode_in);
    assign comp_flags_out.full_n = merge(full_v, depth_mode_in);
    assign comp_flags_out.near_empty_n = merge(near_empty_v, depth_mode_in);
    assign comp_flags_out.near_full_n = merge(near_full_v, depth_mode_in);
    // R09 no half level
    // The pin carries the write token in a chain, so it reads inactive
    assign comp_flags_out.half_n = depth_mode_in ? 1'b1 : &half_v;

endmodule

`default_nettype wire

// file: irq_status.sv
`timescale 1ns/10ps
`default_nettype none

module irq_status #(
    parameter int W = 6
) (
    input wire logic sys_clk_in,            // Clock
    input wire logic sys_rst_in,            // Async reset, active high
    input wire logic [W-1:0] event_in,      // One-cycle event pulses
    input wire logic [W-1:0] clear_in,      // Bits reported by a status read
    input wire logic [W-1:0] mask_in,       // 1 enables the bit onto the line
    output logic [W-1:0] status_out,        // Sticky status
    output logic irq_out                    // Level interrupt
);

    // ----------------------------------------------------------------
    // Sticky bits
    // ----------------------------------------------------------------
    // Set wins over clear, so an event in the clearing cycle survives
    wire logic [W-1:0] next_status = (status_out & ~clear_in) | event_in;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_out <= '0;
            irq_out <= 1'b0;
        end else begin
            status_out <= next_status;
            irq_out <= |(next_status & mask_in);
        end
    end

endmodule

`default_nettype wire

// file: cascade_host.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cascade_cfg.svh"

// What the document requires
// R01: Word width is slices times 18 bits, one device per slice.
// R02: In width mode all devices share one set of control lines.
// R03: Width mode composite empty and full: AND of active-low flags.
// R04: Lead device of a chain gets first load select low.
// R05: All other chained devices get first load select high.
// R06: Write token out of each device feeds write token in of next.
// R07: Read token out of each device feeds read token in of next.
// R08: One shared offset load line drives every device.
// R09: Chained devices give no half level flag.
// R10: Chain composite empty, full, near flags: OR of active-low flags.
// R11: Chain near-empty and near-full composites are only approximate.
// R12: Chain length is unlimited by logic, only by loading.
// R13: Devices ignore replay requests while chained.
// R14: Only the read token holder drives data when output enabled.
// R15: Empty flag is active low and blocks reads; the code lets pops through while the offset load bit is set.
// R16: Lead device holds both tokens after reset and passes them on.
// R17: Devices without a token ignore the matching enable.
module cascade_host #(
    parameter int NUM_DEV = 3,
    parameter int SLICES = 2
) (
    input wire logic sys_clk_in,                                     // Clock, 20 MHz
    input wire logic sys_rst_in,                                     // Async reset, active high
    input wire logic psel_in,                                        // APB select
    input wire logic penable_in,                                     // APB enable
    input wire logic pwrite_in,                                      // APB direction
    input wire logic [7:0] paddr_in,                                 // APB byte address
    input wire logic [31:0] pwdata_in,                               // APB write data
    output logic [31:0] prdata_out,                                  // APB read data
    output logic pready_out,                                         // APB ready
    output logic pslverr_out,                                        // APB error
    output logic irq_out,                                            // Level interrupt
    output logic wr_en_n_out,                                        // Shared write enable
    output logic [SLICES*`SLICE_W-1:0] fifo_data_out,                // Write word
    output logic rd_en_n_out,                                        // Shared read enable
    output logic out_en_n_out,                                       // Shared output enable
    output logic offset_load_n_out,                                  // Shared offset load
    output logic replay_request_out,                                 // Shared replay
    output logic [NUM_DEV-1:0] first_load_select_out,                // Per-device lead strap
    input wire logic [SLICES*`SLICE_W-1:0] fifo_data_in,             // Read word
    input wire cascade_pkg::dev_flags_s [NUM_DEV-1:0] dev_flags_in   // Per-device flags
);

    localparam int WORD_W = SLICES * `SLICE_W;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cascade_pkg::ctrl_s ctrl;
    cascade_pkg::seq_state_e state;
    cascade_pkg::seq_state_e next_state;
    cascade_pkg::dev_flags_s comp;
    logic [`IRQ_W-1:0] irq_mask;
    logic [`IRQ_W-1:0] irq_stat;
    logic [SLICES-1:0][`SLICE_W-1:0] wdata_hold;
    logic [SLICES-1:0][`SLICE_W-1:0] rdata_hold;
    logic [`HOLD_CNT_W-1:0] hold_cnt;
    logic empty_prev;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    wire logic setup_phase = psel_in & ~penable_in;
    wire logic access_phase = psel_in & penable_in;
    wire logic bus_wr = access_phase & pwrite_in;
    wire logic bus_rd = access_phase & ~pwrite_in;
    wire logic hit_ctrl = is_reg(paddr_in, `OFS_CTRL);
    wire logic hit_cmd = is_reg(paddr_in, `OFS_CMD);
    wire logic hit_flags = is_reg(paddr_in, `OFS_FLAGS);
    wire logic hit_status = is_reg(paddr_in, `OFS_IRQ_STATUS);
    wire logic hit_mask = is_reg(paddr_in, `OFS_IRQ_MASK);
    wire logic [2:0] slice_idx = paddr_in[4:2];
    wire logic slice_ok = (int'(slice_idx) < SLICES) && (paddr_in[1:0] == 2'h0);
    wire logic hit_wdata = (paddr_in[7:5] == `DATA_BLOCK_W) && slice_ok;
    wire logic hit_rdata = (paddr_in[7:5] == `DATA_BLOCK_R) && slice_ok;
    wire logic hit_any = hit_ctrl | hit_cmd | hit_flags | hit_status | hit_mask | hit_wdata | hit_rdata;

    // Commands take effect at the access edge
    wire logic cmd_push = bus_wr & hit_cmd & pwdata_in[`CMD_PUSH_BIT];
    wire logic cmd_pop = bus_wr & hit_cmd & pwdata_in[`CMD_POP_BIT];
    wire logic cmd_replay = bus_wr & hit_cmd & pwdata_in[`CMD_REPLAY_BIT];
    wire logic idle = (state == cascade_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // Composite flags
    // ----------------------------------------------------------------
    flag_combine #(
        .NUM_DEV(NUM_DEV)
    ) u_flags (
        .depth_mode_in(ctrl.depth_mode),
        .dev_flags_in(dev_flags_in),
        .comp_flags_out(comp)
    );

    // R15 empty blocks reads
    // Offset loading bypasses the gating
    wire logic empty_blocked = ~comp.empty_n & ~ctrl.offset_load;
    wire logic full_blocked = ~comp.full_n & ~ctrl.offset_load;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // R11 near flags approximate
    // Near flags are composites, not exact levels
    wire logic [31:0] flags_word = {25'h0, ~idle, ~ctrl.depth_mode, comp};
    wire logic [31:0] rdata_word = {`SLICE_PAD'h0, rdata_hold[slice_idx]};
    wire logic [31:0] wdata_word = {`SLICE_PAD'h0, wdata_hold[slice_idx]};
    wire logic [31:0] read_value =
        hit_ctrl ? {29'h0, ctrl} :
        hit_flags ? flags_word :
        hit_status ? {26'h0, irq_stat} :
        hit_mask ? {26'h0, irq_mask} :
        hit_rdata ? rdata_word :
        hit_wdata ? wdata_word : 32'h0;

    // Zero wait states: the read word is latched in the setup cycle
    assign pready_out = 1'b1;
    assign pslverr_out = access_phase & ~hit_any;

    // Clear only the bits the read returned
    wire logic [`IRQ_W-1:0] irq_clear = (bus_rd & hit_status) ? prdata_out[`IRQ_W-1:0] : `IRQ_W'h0;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Control and mask registers
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl <= `CTRL_RESET;
            irq_mask <= `MASK_RESET;
            prdata_out <= 32'h0;
        end else begin
            if (bus_wr & hit_ctrl) begin
                ctrl <= pwdata_in[`CTRL_W-1:0];
            end
            if (bus_wr & hit_mask) begin
                irq_mask <= pwdata_in[`IRQ_W-1:0];
            end
            if (setup_phase) begin
                prdata_out <= read_value;
            end
        end
    end

    // R01 one slice each
    // One register per slice, filled before a push
    for (genvar s = 0; s < SLICES; s++) begin : g_slice
        wire logic slice_wr = bus_wr & hit_wdata & (int'(slice_idx) == s);

        always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                wdata_hold[s] <= `SLICE_W'h0;
                rdata_hold[s] <= `SLICE_W'h0;
            end else begin
                if (slice_wr) begin
                    wdata_hold[s] <= pwdata_in[`SLICE_W-1:0];
                end
                if (state == cascade_pkg::ST_CAPTURE) begin
                    rdata_hold[s] <= fifo_data_in[s*`SLICE_W +: `SLICE_W];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Push wins over pop, pop over replay; commands while busy are dropped
    always_comb begin
        next_state = state;
        case (state)
            cascade_pkg::ST_IDLE: begin
                if (cmd_push) begin
                    next_state = full_blocked ? cascade_pkg::ST_IDLE : cascade_pkg::ST_WRITE;
                end else if (cmd_pop) begin
                    next_state = empty_blocked ? cascade_pkg::ST_IDLE : cascade_pkg::ST_READ;
                end else if (cmd_replay) begin
                    // R13 no replay chained
                    next_state = ctrl.depth_mode ? cascade_pkg::ST_IDLE : cascade_pkg::ST_REPLAY;
                end
            end
            cascade_pkg::ST_WRITE: begin
                next_state = cascade_pkg::ST_IDLE;
            end
            cascade_pkg::ST_READ: begin
                next_state = cascade_pkg::ST_CAPTURE;
            end
            cascade_pkg::ST_CAPTURE: begin
                next_state = cascade_pkg::ST_IDLE;
            end
            cascade_pkg::ST_REPLAY: begin
                next_state = (hold_cnt == `HOLD_CNT_W'h0) ? cascade_pkg::ST_RECOVER : cascade_pkg::ST_REPLAY;
            end
            cascade_pkg::ST_RECOVER: begin
                next_state = (hold_cnt == `HOLD_CNT_W'h0) ? cascade_pkg::ST_IDLE : cascade_pkg::ST_RECOVER;
            end
            default: begin
                next_state = cascade_pkg::ST_IDLE;
            end
        endcase
    end

    // State and replay pulse or recovery counter
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= cascade_pkg::ST_IDLE;
            hold_cnt <= `HOLD_CNT_W'h0;
            empty_prev <= 1'b0;
        end else begin
            state <= next_state;
            empty_prev <= comp.empty_n;
            if (state != next_state) begin
                hold_cnt <= (next_state == cascade_pkg::ST_REPLAY) ?
                    `HOLD_CNT_W'(`REPLAY_PULSE_CYC - 1) : `HOLD_CNT_W'(`REPLAY_RECOVER_CYC - 1);
            end else if (hold_cnt != `HOLD_CNT_W'h0) begin
                hold_cnt <= hold_cnt - `HOLD_CNT_W'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    logic [`IRQ_W-1:0] events;
    assign events[`EV_PUSH_DONE] = (state == cascade_pkg::ST_WRITE);
    assign events[`EV_POP_DONE] = (state == cascade_pkg::ST_CAPTURE);
    assign events[`EV_PUSH_REFUSED] = idle & cmd_push & full_blocked;
    assign events[`EV_POP_REFUSED] = idle & ~cmd_push & cmd_pop & empty_blocked;
    assign events[`EV_REPLAY_REFUSED] = idle & ~cmd_push & ~cmd_pop & cmd_replay & ctrl.depth_mode;
    assign events[`EV_EMPTY_REACHED] = empty_prev & ~comp.empty_n;

    irq_status #(
        .W(`IRQ_W)
    ) u_irq (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .event_in(events),
        .clear_in(irq_clear),
        .mask_in(irq_mask),
        .status_out(irq_stat),
        .irq_out(irq_out)
    );

    // ----------------------------------------------------------------
    // Device pins
    // ----------------------------------------------------------------
    // R02 common controls
    // R12 unlimited chain
    // One set of strobes fans out to every device; the board bounds the fan-out
    // R06 write token ring
    // R07 read token ring
    // R16 lead holds tokens
    // R17 token gates enables
    // Tokens ride board wiring; the shared enables rely on only the holder acting
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_en_n_out <= 1'b1;
            rd_en_n_out <= 1'b1;
            out_en_n_out <= 1'b1;
            offset_load_n_out <= 1'b1;
            replay_request_out <= 1'b0;
            fifo_data_out <= '0;
        end else begin
            wr_en_n_out <= (next_state != cascade_pkg::ST_WRITE);
            rd_en_n_out <= (next_state != cascade_pkg::ST_READ);
            // R14 holder drives data
            // Open output enable for the read; only the holder answers
            out_en_n_out <= ~(ctrl.out_enable | (next_state == cascade_pkg::ST_READ) |
                (next_state == cascade_pkg::ST_CAPTURE));
            // R08 shared offset load
            offset_load_n_out <= ~ctrl.offset_load;
            replay_request_out <= (next_state == cascade_pkg::ST_REPLAY);
            if (idle && next_state == cascade_pkg::ST_WRITE) begin
                fifo_data_out <= WORD_W'(wdata_hold);
            end
        end
    end

    // R04 lead strap low
    // R05 others strap high
    for (genvar d = 0; d < NUM_DEV; d++) begin : g_strap
        always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                first_load_select_out[d] <= 1'b0;
            end else begin
                first_load_select_out[d] <= ctrl.depth_mode & (d != 0);
            end
        end
    end

endmodule

`default_nettype wire

// file: cascade_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cascade_host_chk #(
    parameter int NUM_DEV = 3
) (
    input wire logic sys_clk_in, // Clock
    input wire logic sys_rst_in, // Reset
    input wire logic psel_in, // Select
    input wire logic penable_in, // Enable
    input wire logic pslverr_out, // Error
    input wire logic wr_en_n_out, // Write enable
    input wire logic rd_en_n_out, // Read enable
    input wire logic out_en_n_out, // Output enable
    input wire logic offset_load_n_out, // Offset load
    input wire logic replay_request_out, // Replay
    input wire logic [NUM_DEV-1:0] first_load_select_out, // Straps
    input wire cascade_pkg::dev_flags_s [NUM_DEV-1:0] dev_flags_in // Flags
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [NUM_DEV-1:0] full_v;
    logic [NUM_DEV-1:0] empty_v;
    // Flag columns
    for (genvar d = 0; d < NUM_DEV; d++) begin : g_col
        assign full_v[d] = dev_flags_in[d].full_n;
        assign empty_v[d] = dev_flags_in[d].empty_n;
    end
    // Output enable over pop and capture
    sequence oe_hold;
        !out_en_n_out ##1 !out_en_n_out;
    endsequence
    chk_lead_strap_low: assert property (!first_load_select_out[0])
        else $error("lead strap high");
    chk_rest_straps_same: assert property ((first_load_select_out >> 1) == '0 ||
        (first_load_select_out >> 1) == ({NUM_DEV{1'b1}} >> 1)) else $error("straps differ");
    // no push into a full chain
    chk_push_not_full: assert property ($fell(wr_en_n_out) && offset_load_n_out |-> $past(|full_v))
        else $error("push while full");
    // no pop from an empty chain
    chk_pop_not_empty: assert property ($fell(rd_en_n_out) && offset_load_n_out |-> $past(|empty_v))
        else $error("pop while empty");
    chk_push_pulse_one: assert property ($fell(wr_en_n_out) |=> wr_en_n_out) else $error("long push");
    chk_pop_oe_hold: assert property ($fell(rd_en_n_out) |-> oe_hold ##0 rd_en_n_out)
        else $error("output enable short");
    chk_replay_width: assert property (replay_request_out |-> first_load_select_out == '0)
        else $error("replay in chain");
    chk_replay_recover: assert property (replay_request_out |=> (!replay_request_out)[*2])
        else $error("replay too long");
    chk_err_access: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("error outside access");
endmodule
bind cascade_host cascade_host_chk #(.NUM_DEV(NUM_DEV)) u_chk (.*);
`default_nettype wire

// file: fifo_chain_model.sv
`timescale 1ns/10ps
`default_nettype none
module fifo_chain_model #(
    parameter int NUM_DEV = 3,
    parameter int DEPTH = 4,
    parameter int W = 36
) (
    input wire logic clk_in, // Device clock
    input wire logic rst_in, // Master reset
    input wire logic wr_en_n_in, // Write enable
    input wire logic [W-1:0] data_in, // Write word
    input wire logic rd_en_n_in, // Read enable
    input wire logic out_en_n_in, // Output enable
    input wire logic offset_load_n_in, // Offset load
    input wire logic replay_in, // Replay
    input wire logic [NUM_DEV-1:0] first_load_select_in, // Straps
    output logic [W-1:0] data_out, // Read word
    output cascade_pkg::dev_flags_s [NUM_DEV-1:0] flags_out // Flags
);
    logic [W-1:0] mem [0:63];
    logic [W-1:0] q;
    int wp, rp, cap;
    int cnt [NUM_DEV];
    logic chain;
    // a high strap means a chain of any length
    assign chain = first_load_select_in[NUM_DEV-1];
    assign cap = chain ? DEPTH * NUM_DEV : DEPTH;
    // a word lands in the device owning its location
    always_comb begin
        for (int d = 0; d < NUM_DEV; d++) begin
            cnt[d] = chain ? 0 : wp - rp;
        end
        for (int p = rp; chain && p < wp; p++) begin
            cnt[(p / DEPTH) % NUM_DEV]++;
        end
        for (int d = 0; d < NUM_DEV; d++) begin
            flags_out[d] = {cnt[d] < DEPTH - 1, cnt[d] > 1, chain || cnt[d] <= DEPTH / 2,
                cnt[d] != DEPTH, cnt[d] != 0};
        end
    end
    // flags and offset load gate transfers; no replay in a chain
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp <= 0;
            rp <= 0;
            q <= '0;
        end else begin
            if (!wr_en_n_in && offset_load_n_in && wp - rp < cap) begin
                mem[wp % 64] <= data_in;
                wp <= wp + 1;
            end
            if (!rd_en_n_in && offset_load_n_in && wp != rp) begin
                q <= mem[rp % 64];
                rp <= rp + 1;
            end
            if (replay_in && !chain) rp <= 0;
        end
    end
    // a released bus shows the inverse
    assign data_out = out_en_n_in ? ~q : q;
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int ND = 3, DP = 4, W = 36;
    logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic pready_out, pslverr_out, irq_out, wr_en_n_out, rd_en_n_out, out_en_n_out;
    logic offset_load_n_out, replay_request_out;
    logic [ND-1:0] first_load_select_out;
    logic [W-1:0] fifo_data_out, fifo_data_in, w;
    cascade_pkg::dev_flags_s [ND-1:0] dev_flags_in;
    logic [31:0] exp_q[$];
    logic [W-1:0] word_q[$], hist[$];
    int errors = 0, n_tests = 0, cyc = 0;
    always #25 sys_clk_in = ~sys_clk_in;
    cascade_host #(.NUM_DEV(ND), .SLICES(2)) DUT (.*);
    fifo_chain_model #(.NUM_DEV(ND), .DEPTH(DP), .W(W)) u_dev (.clk_in(sys_clk_in), .rst_in(sys_rst_in),
        .wr_en_n_in(wr_en_n_out), .data_in(fifo_data_out), .rd_en_n_in(rd_en_n_out),
        .out_en_n_in(out_en_n_out), .offset_load_n_in(offset_load_n_out), .replay_in(replay_request_out),
        .first_load_select_in(first_load_select_out), .data_out(fifo_data_in), .flags_out(dev_flags_in));
    task automatic cmp(input string s, input logic [W-1:0] e, input logic [W-1:0] v);
        n_tests++;
        if (v !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bus answers and pushed words are judged as they appear
    always @(posedge sys_clk_in) begin
        cyc++;
        if (psel_in && penable_in && !pwrite_in && pready_out) cmp("prdata", exp_q.pop_front(), prdata_out);
        if (psel_in && penable_in) cmp("pslverr", paddr_in == 8'h14, pslverr_out);
        if (!wr_en_n_out) cmp("word", word_q.pop_front(), fifo_data_out);
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do @(posedge sys_clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [31:0] c);
        apb(1'b1, 8'h04, c);
        repeat (3) @(posedge sys_clk_in);
    endtask
    task automatic push(input logic ok);
        w = W'({$urandom(), $urandom()});
        apb(1'b1, 8'h20, {14'h0, w[17:0]});
        apb(1'b1, 8'h24, {14'h0, w[35:18]});
        if (ok) word_q.push_back(w);
        if (ok) hist.push_back(w);
        cmd(32'h1);
    endtask
    task automatic pop_chk(input logic [W-1:0] e);
        cmd(32'h2);
        rd(8'h40, {14'h0, e[17:0]});
        rd(8'h44, {14'h0, e[35:18]});
    endtask
    task automatic reset_run;
        sys_rst_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    function automatic logic [31:0] flg(input int c, input logic d);
        return {25'h0, 1'b0, !d, c < DP - 1, c > 1, d || c <= DP / 2, c != DP, c != 0};
    endfunction
    initial begin
        void'($urandom(72815));
        reset_run();
        rd(8'h00, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h08, flg(0, 1'b0));
        apb(1'b1, 8'h10, 32'h3F);
        $display("test reset done");
        for (int i = 0; i <= DP; i++) begin
            push(i < DP);
            rd(8'h08, flg(i < DP ? i + 1 : DP, 1'b0));
        end
        cmp("irq", 1, irq_out);
        rd(8'h0C, 32'h05);
        repeat (2) @(posedge sys_clk_in);
        cmp("irq", 0, irq_out);
        for (int i = 0; i < DP; i++) pop_chk(hist[i]);
        cmd(32'h2);
        rd(8'h0C, 32'h2A);
        $display("test width done");
        cmd(32'h4);
        rd(8'h08, flg(DP, 1'b0));
        pop_chk(hist[0]);
        apb(1'b1, 8'h10, 32'h0);
        cmd(32'h2);
        cmp("irq", 0, irq_out);
        rd(8'h0C, 32'h02);
        $display("test replay done");
        reset_run();
        hist.delete();
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h10, 32'h3F);
        rd(8'h08, flg(0, 1'b1));
        for (int i = 0; i <= DP * ND; i++) push(i < DP * ND);
        rd(8'h08, flg(DP, 1'b1));
        cmd(32'h4);
        for (int i = 0; i < DP * ND; i++) pop_chk(hist[i]);
        rd(8'h08, flg(0, 1'b1));
        rd(8'h0C, 32'h37);
        $display("test chain done");
        apb(1'b1, 8'h00, 32'h7);
        push(1'b1);
        cmp("oe", 0, out_en_n_out);
        apb(1'b1, 8'h00, 32'h1);
        rd(8'h08, flg(0, 1'b1));
        $display("test offset done");
        print_verdict();
    end
endmodule
`default_nettype wire
